// *** rtl/crc8_step.sv ***
// one serial step of the frame check remainder, msb first
`timescale 1ns/100ps
`default_nettype none
module crc8_step (
    input  wire logic [7:0] crc_in,
    input  wire logic       bit_in,
    output var  logic [7:0] crc_out
);
    logic feedback;

    always_comb begin
        feedback = crc_in[7] ^ bit_in;
        crc_out  = {crc_in[6:0], 1'b0} ^ (feedback ? fcfc_pkg::CRC_POLY : 8'h00);
    end
endmodule : crc8_step
`default_nettype wire

// *** rtl/fault_clear_and_frame_check.sv ***
// serial frame receiver, status read-back, alarm and clear control of the loop driver
`timescale 1ns/100ps
`default_nettype none
module fault_clear_and_frame_check (
    input  wire logic       REF_CLK,
    input  wire logic       SYS_RST,
    input  wire logic       SCLK,
    input  wire logic       SDIN,
    input  wire logic       FRAME_SYNC_N,
    output var  logic       SDO_O,
    output var  logic       SDO_OE_N,
    input  wire logic [2:0] DEVICE_SELECT,
    input  wire logic       STRAP_MODE_SELECT,
    input  wire logic [3:0] RANGE_PINS,
    input  wire logic       SENSE_RES_PIN,
    input  wire logic       CLEAR,
    input  wire logic       CLEAR_LEVEL_PIN,
    input  wire logic       COMPLIANCE_FAULT,
    input  wire logic       OPEN_LOOP_DET,
    input  wire logic       OVERHEAT_DET,
    input  wire logic       ALARM_OUT_N_I,
    output var  logic       ALARM_OUT_N_O,
    output var  logic       ALARM_OUT_N_OE_N,
    input  wire logic       OPEN_LOOP_ALARM_N_I,
    output var  logic       OPEN_LOOP_ALARM_N_O,
    output var  logic       OPEN_LOOP_ALARM_N_OE_N,
    input  wire logic       OVERHEAT_ALARM_N_I,
    output var  logic       OVERHEAT_ALARM_N_O,
    output var  logic       OVERHEAT_ALARM_N_OE_N,
    output var  logic [3:0] RANGE_CODE,
    output var  logic       ALT_RES_SEL,
    output var  logic       EXT_RES_SEL,
    output var  logic       OUTPUT_DRIVE_ON,
    output var  logic       CLEAR_FORCE,
    output var  logic       CLEAR_TO_MID
);
    fcfc_pkg::pin_type    pin;
    logic [fcfc_pkg::PIN_W-1:0] pin_raw;
    logic [fcfc_pkg::PIN_W-1:0] pin_sync;
    fcfc_pkg::ctrl_type   ctrl_q;
    fcfc_pkg::cmd_type    cmd;
    fcfc_pkg::status_type status_word;
    logic       sclk_prev_q;
    logic       sync_prev_q;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       frame_start;
    logic       frame_end;
    logic       in_frame;
    logic [2:0] strap_wait_q;
    logic       strap_taken_q;
    logic       hw_mode_q;
    logic [4:0] bit_cnt_q;
    logic [23:0] shift_q;
    logic [7:0] crc_q;
    logic [7:0] crc_d;
    logic [2:0] rise_cnt_q;
    logic       len16;
    logic       len24;
    logic       crc_ok;
    logic       accept;
    logic       check_fail;
    logic       read_start;
    logic       err_q;
    logic       sdo_en_q;
    logic       sdo_q;
    logic [15:0] out_sr_q;
    logic       alarm_pull_q;
    logic       ol_pull_q;
    logic       ot_pull_q;

    // the open-drain pins are never read back; inputs kept for the pad trio
    assign pin_raw = {SCLK, SDIN, FRAME_SYNC_N, CLEAR, CLEAR_LEVEL_PIN, COMPLIANCE_FAULT,
                      OPEN_LOOP_DET, OVERHEAT_DET, STRAP_MODE_SELECT, SENSE_RES_PIN,
                      RANGE_PINS, DEVICE_SELECT};

    pin_sync3 #(
        .W    (fcfc_pkg::PIN_W),
        .INIT (fcfc_pkg::PIN_RESET)
    ) u_pin_sync (
        .clk (REF_CLK),
        .rst (SYS_RST),
        .d   (pin_raw),
        .q   (pin_sync)
    );

    assign pin = fcfc_pkg::pin_type'(pin_sync);

    crc8_step u_crc (
        .crc_in  (crc_q),
        .bit_in  (pin.sdin),
        .crc_out (crc_d)
    );

    // edges of the link clock and frame sync, seen on the filtered levels
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            sclk_prev_q <= 1'b0;
            sync_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= pin.sclk;
            sync_prev_q <= pin.frame_sync_n;
        end
    end

    assign sclk_rise   = ~sclk_prev_q & pin.sclk;
    assign sclk_fall   = sclk_prev_q & ~pin.sclk;
    assign frame_start = sync_prev_q & ~pin.frame_sync_n;
    assign frame_end   = ~sync_prev_q & pin.frame_sync_n;
    assign in_frame    = ~pin.frame_sync_n;

    // strap caught once the synchroniser has settled after reset
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            strap_wait_q  <= 3'h0;
            strap_taken_q <= 1'b0;
            hw_mode_q     <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_wait_q <= strap_wait_q + 3'h1;
            if (strap_wait_q == fcfc_pkg::STRAP_SETTLE) begin
                strap_taken_q <= 1'b1;
                hw_mode_q     <= pin.strap_mode_select;
            end
        end
    end

    // receive shift register; bits taken on falling link clock edges
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            bit_cnt_q <= 5'h00;
            shift_q   <= 24'h000000;
            crc_q     <= fcfc_pkg::CRC_INIT;
        end else if (frame_start) begin
            bit_cnt_q <= 5'h00;
            crc_q     <= fcfc_pkg::CRC_INIT;
        end else if (sclk_fall && in_frame && !hw_mode_q) begin
            shift_q <= {shift_q[22:0], pin.sdin};
            if (bit_cnt_q != fcfc_pkg::BIT_CNT_MAX) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            // remainder runs over the data bits only, never the check byte
            if (bit_cnt_q < fcfc_pkg::DATA_BITS) begin
                crc_q <= crc_d;
            end
        end
    end

    // frame end decode
    always_comb begin
        len16      = (bit_cnt_q == fcfc_pkg::DATA_BITS);
        len24      = (bit_cnt_q == fcfc_pkg::FRAME_CHK_BITS);
        cmd        = fcfc_pkg::cmd_type'(len24 ? shift_q[23:8] : shift_q[15:0]);
        crc_ok     = (shift_q[7:0] == crc_q);
        accept     = frame_end && !hw_mode_q && (cmd.device_select == pin.device_select)
                     && (len16 || (len24 && crc_ok));
        check_fail = frame_end && !hw_mode_q && len24 && !crc_ok;
    end

    // control register, written only by accepted frames
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ctrl_q <= fcfc_pkg::CTRL_RESET;
        end else if (accept) begin
            if (cmd.soft_reset) begin
                ctrl_q <= fcfc_pkg::CTRL_RESET;
            end else begin
                ctrl_q.range_code            <= cmd.range_code;
                ctrl_q.clear_level_select    <= cmd.clear_level_select;
                ctrl_q.output_drive_on       <= cmd.output_drive_on;
                ctrl_q.sense_resistor_select <= cmd.sense_resistor_select;
                ctrl_q.soft_clear            <= cmd.soft_clear;
            end
        end
    end

    // frame check error flag; a new failure beats the clear from a read
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            err_q <= 1'b0;
        end else if (check_fail) begin
            err_q <= 1'b1;
        end else if (frame_end && sdo_en_q) begin
            err_q <= 1'b0;
        end
    end

    always_comb begin
        status_word.device_select         = pin.device_select;
        status_word.fixed_one             = 1'b1;
        status_word.fixed_zero            = 1'b0;
        status_word.range_code            = ctrl_q.range_code;
        status_word.clear_level_select    = ctrl_q.clear_level_select;
        status_word.output_drive_on       = ctrl_q.output_drive_on;
        status_word.sense_resistor_select = ctrl_q.sense_resistor_select;
        status_word.frame_check_error     = err_q;
        status_word.overheat_flag         = pin.overheat_det;
        status_word.open_loop_flag        = pin.open_loop_det;
        status_word.unused                = 1'b0;
    end

    // read starts on the fifth rising edge of the frame, the first after address and read bit arrive
    assign read_start = sclk_rise && in_frame && !hw_mode_q
                        && (rise_cnt_q == fcfc_pkg::READ_START_EDGE - 3'h1)
                        && (bit_cnt_q == fcfc_pkg::READ_ADDR_BITS) && shift_q[0]
                        && (shift_q[3:1] == pin.device_select);

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            rise_cnt_q <= 3'h0;
        end else if (frame_start) begin
            rise_cnt_q <= 3'h0;
        end else if (sclk_rise && in_frame && rise_cnt_q != fcfc_pkg::READ_START_EDGE) begin
            rise_cnt_q <= rise_cnt_q + 3'h1;
        end
    end

    // serial output; released at frame end so several devices share the line
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            sdo_en_q <= 1'b0;
            sdo_q    <= 1'b0;
            out_sr_q <= 16'h0000;
        end else if (frame_end) begin
            sdo_en_q <= 1'b0;
        end else if (read_start) begin
            sdo_en_q <= 1'b1;
            out_sr_q <= status_word;
            sdo_q    <= status_word[15];
        end else if (sdo_en_q && sclk_rise) begin
            out_sr_q <= {out_sr_q[14:0], 1'b0};
            sdo_q    <= out_sr_q[14];
        end
    end

    assign SDO_O    = sdo_q;
    assign SDO_OE_N = ~sdo_en_q;

    // alarms and analog controls, all registered
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            alarm_pull_q    <= 1'b0;
            ol_pull_q       <= 1'b0;
            ot_pull_q       <= 1'b0;
            RANGE_CODE      <= fcfc_pkg::CTRL_RESET.range_code;
            ALT_RES_SEL     <= 1'b0;
            EXT_RES_SEL     <= 1'b0;
            OUTPUT_DRIVE_ON <= 1'b0;
            CLEAR_FORCE     <= 1'b0;
            CLEAR_TO_MID    <= 1'b0;
        end else begin
            // compliance input already carries the headroom warning
            alarm_pull_q <= !hw_mode_q && (pin.compliance_fault || pin.open_loop_det
                            || err_q || check_fail || pin.overheat_det);
            ol_pull_q    <= hw_mode_q && pin.open_loop_det;
            ot_pull_q    <= hw_mode_q && pin.overheat_det;
            if (hw_mode_q) begin
                RANGE_CODE      <= pin.range_pins;
                ALT_RES_SEL     <= (pin.range_pins == fcfc_pkg::OVR_RANGE_A)
                                   || (pin.range_pins == fcfc_pkg::OVR_RANGE_B);
                EXT_RES_SEL     <= ~pin.sense_res_pin;
                OUTPUT_DRIVE_ON <= 1'b1;
            end else begin
                RANGE_CODE      <= ctrl_q.range_code;
                ALT_RES_SEL     <= (ctrl_q.range_code == fcfc_pkg::OVR_RANGE_A)
                                   || (ctrl_q.range_code == fcfc_pkg::OVR_RANGE_B);
                EXT_RES_SEL     <= ~ctrl_q.sense_resistor_select;
                OUTPUT_DRIVE_ON <= ctrl_q.output_drive_on;
            end
            // level is held, so the programmed value returns on release
            CLEAR_FORCE  <= pin.clear || (!hw_mode_q && ctrl_q.soft_clear);
            CLEAR_TO_MID <= pin.clear_level_pin || ctrl_q.clear_level_select;
        end
    end

    assign ALARM_OUT_N_O          = 1'b0;
    assign ALARM_OUT_N_OE_N       = ~alarm_pull_q;
    assign OPEN_LOOP_ALARM_N_O    = 1'b0;
    assign OPEN_LOOP_ALARM_N_OE_N = ~ol_pull_q;
    assign OVERHEAT_ALARM_N_O     = 1'b0;
    assign OVERHEAT_ALARM_N_OE_N  = ~ot_pull_q;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_read_begin;
        read_start ##1 (sdo_en_q && !SDO_OE_N);
    endsequence

    property p_status_layout;
        $rose(sdo_en_q) |-> (out_sr_q[12:11] == 2'b10) && !out_sr_q[0]
                            && (out_sr_q[10:7] == ctrl_q.range_code) && (SDO_O == out_sr_q[15]);
    endproperty
    a_status_layout: assert property (p_status_layout) else $error("bad status layout");

    property p_fail_sets_error;
        check_fail |=> err_q ##1 !ALARM_OUT_N_OE_N;
    endproperty
    a_fail_sets_error: assert property (p_fail_sets_error) else $error("check error lost");

    property p_fail_no_write;
        (check_fail || (frame_end && !len16 && !len24)) |=> $stable(ctrl_q);
    endproperty
    a_fail_no_write: assert property (p_fail_no_write) else $error("bad frame wrote");

    property p_read_clears;
        (frame_end && sdo_en_q && !check_fail) |=> !err_q && SDO_OE_N;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear");

    property p_read_start;
        s_read_begin |-> out_sr_q[15:13] == $past(pin.device_select);
    endproperty
    a_read_start: assert property (p_read_start) else $error("read start wrong");

    property p_sw_alarm;
        (!hw_mode_q && $stable(hw_mode_q) && (pin.overheat_det || pin.compliance_fault))
            |=> !ALARM_OUT_N_OE_N;
    endproperty
    a_sw_alarm: assert property (p_sw_alarm) else $error("alarm not pulled");

    property p_hw_alarm;
        (hw_mode_q && pin.open_loop_det) |=> !OPEN_LOOP_ALARM_N_OE_N && ALARM_OUT_N_OE_N;
    endproperty
    a_hw_alarm: assert property (p_hw_alarm) else $error("open loop alarm missing");

    property p_clear_level;
        ##1 CLEAR_TO_MID == $past(pin.clear_level_pin || ctrl_q.clear_level_select);
    endproperty
    a_clear_level: assert property (p_clear_level) else $error("clear level wrong");

    property p_clear_force;
        pin.clear |=> CLEAR_FORCE;
    endproperty
    a_clear_force: assert property (p_clear_force) else $error("clear not forced");

    property p_overrange;
        ALT_RES_SEL == ((RANGE_CODE == fcfc_pkg::OVR_RANGE_A)
                        || (RANGE_CODE == fcfc_pkg::OVR_RANGE_B));
    endproperty
    a_overrange: assert property (p_overrange) else $error("overrange resistor wrong");

    property p_hw_no_status;
        hw_mode_q |-> SDO_OE_N;
    endproperty
    a_hw_no_status: assert property (p_hw_no_status) else $error("status in hw mode");

endmodule : fault_clear_and_frame_check
`default_nettype wire

// *** rtl/fcfc_pkg.sv ***
// shared types and constants for the fault, clear and frame check block
package fcfc_pkg;

    // packed pin group sampled through the three-stage synchroniser
    typedef struct packed {
        logic       sclk;
        logic       sdin;
        logic       frame_sync_n;
        logic       clear;
        logic       clear_level_pin;
        logic       compliance_fault;
        logic       open_loop_det;
        logic       overheat_det;
        logic       strap_mode_select;
        logic       sense_res_pin;
        logic [3:0] range_pins;
        logic [2:0] device_select;
    } pin_type;

    // status read-back word, D15 down to D0
    typedef struct packed {
        logic [2:0] device_select;
        logic       fixed_one;
        logic       fixed_zero;
        logic [3:0] range_code;
        logic       clear_level_select;
        logic       output_drive_on;
        logic       sense_resistor_select;
        logic       frame_check_error;
        logic       overheat_flag;
        logic       open_loop_flag;
        logic       unused;
    } status_type;

    // received 16-bit command word, D15 down to D0
    typedef struct packed {
        logic [2:0] device_select;
        logic       read_request;
        logic       reserved;
        logic [3:0] range_code;
        logic       clear_level_select;
        logic       output_drive_on;
        logic       sense_resistor_select;
        logic       soft_clear;
        logic       soft_reset;
        logic [1:0] unused;
    } cmd_type;

    // software-programmed control state
    typedef struct packed {
        logic [3:0] range_code;
        logic       clear_level_select;
        logic       output_drive_on;
        logic       sense_resistor_select;
        logic       soft_clear;
    } ctrl_type;

    localparam int          PIN_W           = 17;
    localparam logic [16:0] PIN_RESET       = 17'h04000; // sync held at idle high
    localparam ctrl_type    CTRL_RESET      = 8'h02;
    localparam logic [4:0]  DATA_BITS       = 5'h10;
    localparam logic [4:0]  FRAME_CHK_BITS  = 5'h18;
    localparam logic [4:0]  BIT_CNT_MAX     = 5'h19;
    localparam logic [4:0]  READ_ADDR_BITS  = 5'h04;
    localparam logic [2:0]  READ_START_EDGE = 3'h5;
    localparam logic [4:0]  SDO_BITS        = 5'h10;
    localparam logic [7:0]  CRC_POLY        = 8'h07;
    localparam logic [7:0]  CRC_INIT        = 8'h00;
    localparam logic [3:0]  OVR_RANGE_A     = 4'hD;
    localparam logic [3:0]  OVR_RANGE_B     = 4'hF;
    localparam logic [2:0]  STRAP_SETTLE    = 3'h5;

endpackage : fcfc_pkg

// *** rtl/pin_sync3.sv ***
// three-stage synchroniser with an output flop that accepts a change once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
    parameter int                W    = 1,
    parameter logic [W-1:0]      INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            q    <= INIT;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // a bit moves only when the last two stages agree
            q    <= (s2_q & ~(s2_q ^ s3_q)) | (q & (s2_q ^ s3_q));
        end
    end
endmodule : pin_sync3
`default_nettype wire

// *** test/fault_clear_and_frame_check_bench.sv ***
// self-checking bench for the fault, clear and frame check block
`timescale 1ns/100ps
`default_nettype none
module fault_clear_and_frame_check_bench;
    logic        REF_CLK, SYS_RST, SCLK, SDIN, FRAME_SYNC_N, SDO_O, SDO_OE_N;
    logic        STRAP_MODE_SELECT, SENSE_RES_PIN, CLEAR, CLEAR_LEVEL_PIN;
    logic        COMPLIANCE_FAULT, OPEN_LOOP_DET, OVERHEAT_DET, ALT_RES_SEL;
    logic        EXT_RES_SEL, ALARM_OUT_N_O, ALARM_OUT_N_OE_N, OPEN_LOOP_ALARM_N_O;
    logic        OPEN_LOOP_ALARM_N_OE_N, OVERHEAT_ALARM_N_O, OVERHEAT_ALARM_N_OE_N;
    logic        OUTPUT_DRIVE_ON, CLEAR_FORCE, CLEAR_TO_MID, e_err;
    logic [2:0]  DEVICE_SELECT;
    logic [3:0]  RANGE_PINS, RANGE_CODE;
    logic [7:0]  e_f;
    logic [31:0] s;
    int          mismatches, check_count;
    wire logic   ALARM_OUT_N_I, OPEN_LOOP_ALARM_N_I, OVERHEAT_ALARM_N_I;
    // pulled-up open-drain wires
    assign ALARM_OUT_N_I = ALARM_OUT_N_OE_N ? 1'b1 : ALARM_OUT_N_O;
    assign OPEN_LOOP_ALARM_N_I = OPEN_LOOP_ALARM_N_OE_N ? 1'b1 : OPEN_LOOP_ALARM_N_O;
    assign OVERHEAT_ALARM_N_I = OVERHEAT_ALARM_N_OE_N ? 1'b1 : OVERHEAT_ALARM_N_O;
    fault_clear_and_frame_check fault_clear_and_frame_check_i (
        .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SCLK(SCLK), .SDIN(SDIN),
        .FRAME_SYNC_N(FRAME_SYNC_N), .SDO_O(SDO_O), .SDO_OE_N(SDO_OE_N),
        .DEVICE_SELECT(DEVICE_SELECT), .STRAP_MODE_SELECT(STRAP_MODE_SELECT),
        .RANGE_PINS(RANGE_PINS), .SENSE_RES_PIN(SENSE_RES_PIN), .CLEAR(CLEAR),
        .CLEAR_LEVEL_PIN(CLEAR_LEVEL_PIN), .COMPLIANCE_FAULT(COMPLIANCE_FAULT),
        .OPEN_LOOP_DET(OPEN_LOOP_DET), .OVERHEAT_DET(OVERHEAT_DET),
        .ALARM_OUT_N_I(ALARM_OUT_N_I), .ALARM_OUT_N_O(ALARM_OUT_N_O),
        .ALARM_OUT_N_OE_N(ALARM_OUT_N_OE_N), .OPEN_LOOP_ALARM_N_I(OPEN_LOOP_ALARM_N_I),
        .OPEN_LOOP_ALARM_N_O(OPEN_LOOP_ALARM_N_O),
        .OPEN_LOOP_ALARM_N_OE_N(OPEN_LOOP_ALARM_N_OE_N),
        .OVERHEAT_ALARM_N_I(OVERHEAT_ALARM_N_I), .OVERHEAT_ALARM_N_O(OVERHEAT_ALARM_N_O),
        .OVERHEAT_ALARM_N_OE_N(OVERHEAT_ALARM_N_OE_N), .RANGE_CODE(RANGE_CODE),
        .ALT_RES_SEL(ALT_RES_SEL), .EXT_RES_SEL(EXT_RES_SEL),
        .OUTPUT_DRIVE_ON(OUTPUT_DRIVE_ON), .CLEAR_FORCE(CLEAR_FORCE),
        .CLEAR_TO_MID(CLEAR_TO_MID)
    );
    host_link_model host_link_model_i (
        .sdo(SDO_O), .sdo_oe_n(SDO_OE_N), .sclk(SCLK), .sdin(SDIN),
        .frame_sync_n(FRAME_SYNC_N)
    );
    initial begin
        REF_CLK = 1'b0;
        forever #50 REF_CLK = ~REF_CLK;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc8
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic outs();
        chk(16'(RANGE_CODE), 16'(e_f[7:4]));
        chk(16'(ALT_RES_SEL), 16'(e_f[7:4] == 4'hD || e_f[7:4] == 4'hF));
        chk(16'(EXT_RES_SEL), 16'(!e_f[1]));
        chk(16'(OUTPUT_DRIVE_ON), 16'(e_f[2]));
        chk(16'(CLEAR_FORCE), 16'(CLEAR | e_f[0]));
        chk(16'(CLEAR_TO_MID), 16'(CLEAR_LEVEL_PIN | e_f[3]));
        chk(16'(ALARM_OUT_N_I),
            16'(~|{e_err, COMPLIANCE_FAULT, OPEN_LOOP_DET, OVERHEAT_DET}));
    endtask : outs
    // f holds range, clear level, drive, resistor and soft clear
    task automatic frame(input logic rd, input logic bad, input int len, input logic [2:0] ds,
                         input logic [7:0] f);
        logic [15:0] w;
        logic [15:0] st;
        w = {ds, rd, 1'b0, f, 3'h0};
        st = {DEVICE_SELECT, 2'b10, e_f[7:1], e_err, OVERHEAT_DET, OPEN_LOOP_DET, 1'b0};
        host_link_model_i.xfer({w, crc8(w) ^ {7'h00, bad}}, len);
        @(negedge REF_CLK);
        if (rd && ds === DEVICE_SELECT) begin
            chk(host_link_model_i.rdata, st);
        end
        if (ds === DEVICE_SELECT && (len == 16 || (len == 24 && !bad))) e_f = f;
        if (rd && ds === DEVICE_SELECT) e_err = 1'b0;
        if (len == 24 && bad) e_err = 1'b1;
        outs();
    endtask : frame
    initial begin
        #3000000;
        mismatches++;
        complete_run();
    end
    initial begin
        {SYS_RST, STRAP_MODE_SELECT, SENSE_RES_PIN, CLEAR, CLEAR_LEVEL_PIN} = 5'h10;
        {COMPLIANCE_FAULT, OPEN_LOOP_DET, OVERHEAT_DET, RANGE_PINS} = 7'h00;
        DEVICE_SELECT = 3'h5;
        s = 32'hAA7C;
        e_f = fcfc_pkg::CTRL_RESET;
        e_err = 1'b0;
        repeat (6) @(negedge REF_CLK);
        SYS_RST = 1'b0;
        repeat (12) @(negedge REF_CLK);
        chk(16'(SDO_OE_N), 16'h0001);
        outs();
        for (int i = 0; i < 16; i++) begin
            s = xs(s);
            frame(1'b0, 1'b0, 16, 3'h5, {i[3:0], s[3:0]});
        end
        $display("test range codes done");
        s = xs(s);
        frame(1'b0, 1'b0, 24, 3'h5, s[7:0]);
        frame(1'b0, 1'b1, 24, 3'h5, ~s[7:0]);
        frame(1'b1, 1'b0, 24, 3'h5, s[15:8]);
        frame(1'b0, 1'b0, 20, 3'h5, s[23:16]);
        frame(1'b1, 1'b0, 16, 3'h2, s[31:24]);
        frame(1'b1, 1'b0, 24, 3'h5, 8'hF9);
        // a failed check inside a read frame must leave the error set
        frame(1'b1, 1'b1, 24, 3'h5, s[7:0]);
        // soft reset word brings the control defaults back
        host_link_model_i.xfer(24'hA00400, 16);
        @(negedge REF_CLK);
        e_f = fcfc_pkg::CTRL_RESET;
        outs();
        $display("test frame check done");
        for (int i = 0; i < 4; i++) begin
            {CLEAR, CLEAR_LEVEL_PIN} = i[1:0];
            repeat (8) @(negedge REF_CLK);
            outs();
            frame(1'b0, 1'b0, 16, 3'h5, {4'h0, i[0], 2'h1, i[1]});
        end
        // pins released so the fault frames show the register bits alone
        {CLEAR, CLEAR_LEVEL_PIN} = 2'h0;
        $display("test clear done");
        for (int i = 1; i < 8; i++) begin
            {COMPLIANCE_FAULT, OPEN_LOOP_DET, OVERHEAT_DET} = i[2:0];
            repeat (8) @(negedge REF_CLK);
            s = xs(s);
            frame(1'b1, 1'b0, 24, 3'h5, s[7:0]);
        end
        $display("test faults done");
        {SYS_RST, STRAP_MODE_SELECT} = 2'b11;
        repeat (6) @(negedge REF_CLK);
        SYS_RST = 1'b0;
        repeat (12) @(negedge REF_CLK);
        for (int i = 0; i < 5; i++) begin
            @(negedge REF_CLK);
            s = xs(s);
            {RANGE_PINS, SENSE_RES_PIN, OPEN_LOOP_DET, OVERHEAT_DET} = i ? s[6:0] : 7'h7A;
            COMPLIANCE_FAULT = 1'b0;
            // read request too: no status may come out in this mode
            host_link_model_i.xfer(24'hB0C000, 16);
            chk(16'(RANGE_CODE), 16'(RANGE_PINS));
            chk(16'(ALT_RES_SEL), 16'(RANGE_PINS == 4'hD || RANGE_PINS == 4'hF));
            chk(16'(EXT_RES_SEL), 16'(!SENSE_RES_PIN));
            chk(16'(OPEN_LOOP_ALARM_N_I), 16'(!OPEN_LOOP_DET));
            chk(16'(OVERHEAT_ALARM_N_I), 16'(!OVERHEAT_DET));
            chk(16'(ALARM_OUT_N_I), 16'h0001);
            chk(16'(OUTPUT_DRIVE_ON), 16'h0001);
            chk(16'(SDO_OE_N), 16'h0001);
        end
        $display("test hardware mode done");
        complete_run();
    end
endmodule : fault_clear_and_frame_check_bench
`default_nettype wire

// *** test/host_link_model.sv ***
// host side of the three-wire link: frame driver and read-back capture
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
    input  wire logic sdo,
    input  wire logic sdo_oe_n,
    output var  logic sclk,
    output var  logic sdin,
    output var  logic frame_sync_n
);
    logic [15:0] rdata;
    initial begin
        sclk = 1'b0;
        sdin = 1'b0;
        frame_sync_n = 1'b1;
        rdata = 16'h0000;
    end
    // clock stands low between frames; odd offset keeps it off the bench clock phase
    task automatic xfer(input logic [23:0] frame, input int len);
        #37;
        rdata = 16'h0000;
        frame_sync_n = 1'b0;
        #400;
        for (int i = 0; i < len; i++) begin
            sdin = frame[23 - i];
            sclk = 1'b1;
            #400;
            sclk = 1'b0;
            #200;
            // undriven output must not pass as data
            if (i >= 4 && i < 20) rdata = {rdata[14:0], sdo_oe_n ? 1'bx : sdo};
            #200;
        end
        sdin = ~sdin;
        #400;
        frame_sync_n = 1'b1;
        #1200;
    endtask : xfer
endmodule : host_link_model
`default_nettype wire
